// ==== analog_config_register_slice.v ====
// Analog configuration registers behind an Avalon-MM slave port.
// Notes on behaviour
// [R1] First-source level in 3:0, zero is off.
// [R2] Codes one to ten select fixed currents.
// [R3] Positive reference select in 5:3, five sources.
// [R4] Negative reference select in 2:0, five sources.
// [R5] Reference register at index 0Fh, resets zero.
// [R6] Positive DAC connect bit routes to input six.
// [R7] Positive DAC level: midscale, above, below codes.
// [R8] Positive DAC register at index 10h, resets zero.
// [R9] Negative DAC register mirrors positive layout.
// [R10] Negative DAC connect bit routes to input seven.
// [R11] Reserved bits read zero, writes ignored.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "analog_config_map.vh"

module analog_config_register_slice (
	input  wire        ref_clk,
	input  wire        rst_b,
	input  wire [7:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	input  wire [3:0]  byteenable,
	output reg  [31:0] readdata,
	output wire        waitrequest,
	output reg  [1:0]  response,
	output reg  [3:0]  firstSourceLevel,
	output reg  [11:0] firstSourceMicroamps,
	output reg         firstSourceOn,
	output reg         firstSourceReservedCode,
	output reg  [4:0]  refPositiveSelect,
	output reg  [4:0]  refNegativeSelect,
	output reg         refPositiveReservedCode,
	output reg         refNegativeReservedCode,
	output reg         positiveDacConnect,
	output reg         negativeDacConnect,
	output reg  [4:0]  positiveDacLevel,
	output reg  [4:0]  negativeDacLevel,
	output wire        positiveDacAboveMid,
	output wire        positiveDacBelowMid,
	output wire        positiveDacReservedCode,
	output wire        negativeDacAboveMid,
	output wire        negativeDacBelowMid,
	output wire        negativeDacReservedCode
);

	// Software-visible registers.
	reg  [7:0]  excitationLevelReg;
	reg  [7:0]  referenceSelectReg;
	reg  [7:0]  testDacPositive;
	reg  [7:0]  testDacNegative;

	// Bus handshake state and decode.
	localparam  BUS_IDLE   = 1'b0;
	localparam  BUS_ANSWER = 1'b1;
	reg         busState;
	reg         next_busState;
	wire        ack;
	wire        request;
	wire [5:0]  regIndex;
	wire        hitExcitation;
	wire        hitReference;
	wire        hitDacPositive;
	wire        hitDacNegative;
	wire        hitStatus;
	wire        mapped;
	wire        writeCommit;
	reg  [7:0]  next_readByte;
	wire [7:0]  analogStatus;

	// Next values for the analog-facing outputs.
	reg  [11:0] next_microamps;
	reg         next_levelReserved;
	reg  [4:0]  next_refPositive;
	reg  [4:0]  next_refNegative;
	reg         next_refPosReserved;
	reg         next_refNegReserved;

	// Per-DAC decode results, channel 0 positive and channel 1 negative.
	wire [9:0]  dacCodes;
	wire [1:0]  decValid;
	wire [1:0]  decAbove;
	wire [1:0]  decBelow;
	reg  [1:0]  dacAbove;
	reg  [1:0]  dacBelow;
	reg  [1:0]  dacReserved;

	// A request is held until the slave drops waitrequest for one cycle.
	assign request     = read | write;
	assign waitrequest = request & ~ack;

	// Word index from the byte address; the two low bits are ignored.
	assign regIndex       = address[7:2];
	assign hitExcitation  = (regIndex == `IDX_EXCITATION);
	assign hitReference   = (regIndex == `IDX_REFERENCE);     // R5
	assign hitDacPositive = (regIndex == `IDX_DAC_POSITIVE);  // R8
	assign hitDacNegative = (regIndex == `IDX_DAC_NEGATIVE);  // R9
	assign hitStatus      = (regIndex == `IDX_ANALOG_STATUS);
	assign mapped         = hitExcitation | hitReference | hitDacPositive |
		hitDacNegative | hitStatus;

	// A write with byteenable[0] set lands on the edge where waitrequest is sampled low.
	assign writeCommit = write & ack & byteenable[0];

	// Live state of the analog side, read only.
	assign analogStatus = {2'h0, dacReserved, refNegativeReservedCode,
		refPositiveReservedCode, firstSourceReservedCode, firstSourceOn};

	// The answer state follows every first request cycle and lasts one cycle.
	always @* begin
		case (busState)
			BUS_IDLE: begin
				if (request) begin
					next_busState = BUS_ANSWER;
				end else begin
					next_busState = BUS_IDLE;
				end
			end
			BUS_ANSWER: next_busState = BUS_IDLE;
			default:    next_busState = BUS_IDLE;
		endcase
	end

	// Handshake state register; reset leaves the slave idle.
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			busState <= BUS_IDLE;
		end else begin
			busState <= next_busState;
		end
	end

	// Waitrequest drops while the slave is in the answer state.
	assign ack = (busState == BUS_ANSWER);

	// Read data selection; unmapped words and reserved bits give zero.
	always @* begin
		case (1'b1)
			hitExcitation:  next_readByte = excitationLevelReg;
			hitReference:   next_readByte = referenceSelectReg;
			hitDacPositive: next_readByte = testDacPositive;
			hitDacNegative: next_readByte = testDacNegative;
			hitStatus:      next_readByte = analogStatus;
			default:        next_readByte = `RESET_BYTE;
		endcase
	end

	// Read data are loaded one edge before the answer and stand through it.
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			readdata <= `RESET_WORD;
		end else if (request & ~ack) begin
			readdata <= {24'h000000, next_readByte & {8{read}}};
		end
	end

	// The response code is loaded with the read data; unmapped words fail.
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			response <= `RESP_OKAY;
		end else if (request & ~ack) begin
			response <= mapped ? `RESP_OKAY : `RESP_DECODE_ERROR;
		end
	end

	// Excitation level register keeps only its level field.
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			excitationLevelReg <= `RESET_BYTE;  // R1
		end else if (writeCommit & hitExcitation) begin
			excitationLevelReg <= writedata[7:0] & `MASK_EXCITATION;  // R11
		end
	end

	// Reference register drops writes to its two top bits.
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			referenceSelectReg <= `RESET_BYTE;  // R5
		end else if (writeCommit & hitReference) begin
			referenceSelectReg <= writedata[7:0] & `MASK_REFERENCE;  // R11
		end
	end

	// Positive test DAC register drops writes to its reserved bits.
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			testDacPositive <= `RESET_BYTE;  // R8
		end else if (writeCommit & hitDacPositive) begin
			testDacPositive <= writedata[7:0] & `MASK_DAC;  // R11
		end
	end

	// Negative test DAC register uses the same layout and mask.
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			testDacNegative <= `RESET_BYTE;  // R9
		end else if (writeCommit & hitDacNegative) begin
			testDacNegative <= writedata[7:0] & `MASK_DAC;  // R9
		end
	end

	// Level code to source current; reserved codes leave the source off.
	always @* begin
		next_levelReserved = 1'b0;
		case (excitationLevelReg[`LEVEL_MSB:`LEVEL_LSB])
			4'h0:    next_microamps = `RESET_CURRENT;  // R1
			4'h1:    next_microamps = `CURRENT_UA_1;   // R2
			4'h2:    next_microamps = `CURRENT_UA_2;
			4'h3:    next_microamps = `CURRENT_UA_3;
			4'h4:    next_microamps = `CURRENT_UA_4;
			4'h5:    next_microamps = `CURRENT_UA_5;
			4'h6:    next_microamps = `CURRENT_UA_6;
			4'h7:    next_microamps = `CURRENT_UA_7;
			4'h8:    next_microamps = `CURRENT_UA_8;
			4'h9:    next_microamps = `CURRENT_UA_9;
			4'hA:    next_microamps = `CURRENT_UA_10;
			default: begin
				next_microamps     = `RESET_CURRENT;
				next_levelReserved = 1'b1;  // R1
			end
		endcase
	end

	// Positive reference code to a one-hot switch set.
	always @* begin
		next_refPosReserved = 1'b0;
		case (referenceSelectReg[`REFP_MSB:`REFP_LSB])
			`REFSEL_INTERNAL: next_refPositive = `ONEHOT_INTERNAL;  // R3
			`REFSEL_INPUT_A:  next_refPositive = `ONEHOT_INPUT_A;
			`REFSEL_INPUT_B:  next_refPositive = `ONEHOT_INPUT_B;
			`REFSEL_INPUT_C:  next_refPositive = `ONEHOT_INPUT_C;
			`REFSEL_SUPPLY:   next_refPositive = `ONEHOT_SUPPLY;
			default: begin
				next_refPositive    = `RESET_SELECT;
				next_refPosReserved = 1'b1;  // R3
			end
		endcase
	end

	// Negative reference code to a one-hot switch set.
	always @* begin
		next_refNegReserved = 1'b0;
		case (referenceSelectReg[`REFN_MSB:`REFN_LSB])
			`REFSEL_INTERNAL: next_refNegative = `ONEHOT_INTERNAL;  // R4
			`REFSEL_INPUT_A:  next_refNegative = `ONEHOT_INPUT_A;
			`REFSEL_INPUT_B:  next_refNegative = `ONEHOT_INPUT_B;
			`REFSEL_INPUT_C:  next_refNegative = `ONEHOT_INPUT_C;
			`REFSEL_SUPPLY:   next_refNegative = `ONEHOT_SUPPLY;
			default: begin
				next_refNegative    = `RESET_SELECT;
				next_refNegReserved = 1'b1;  // R4
			end
		endcase
	end

	// First-source outputs follow the level register one cycle later.
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			firstSourceLevel        <= `LEVEL_OFF;
			firstSourceMicroamps    <= `RESET_CURRENT;
			firstSourceOn           <= 1'b0;
			firstSourceReservedCode <= 1'b0;
		end else begin
			firstSourceLevel <=
				excitationLevelReg[`LEVEL_MSB:`LEVEL_LSB];  // R1
			firstSourceMicroamps    <= next_microamps;  // R2
			firstSourceOn           <= (next_microamps != `RESET_CURRENT);
			firstSourceReservedCode <= next_levelReserved;
		end
	end

	// Reference switch sets follow the reference register one cycle later.
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			refPositiveSelect       <= `ONEHOT_INTERNAL;  // R5
			refNegativeSelect       <= `ONEHOT_INTERNAL;  // R5
			refPositiveReservedCode <= 1'b0;
			refNegativeReservedCode <= 1'b0;
		end else begin
			refPositiveSelect       <= next_refPositive;  // R3
			refNegativeSelect       <= next_refNegative;  // R4
			refPositiveReservedCode <= next_refPosReserved;
			refNegativeReservedCode <= next_refNegReserved;
		end
	end

	// Test DAC connect and level outputs follow their registers.
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			positiveDacConnect      <= 1'b0;
			negativeDacConnect      <= 1'b0;
			positiveDacLevel        <= `DAC_MIDSCALE;
			negativeDacLevel        <= `DAC_MIDSCALE;
		end else begin
			positiveDacConnect <= testDacPositive[`CONNECT_BIT];  // R6
			negativeDacConnect <= testDacNegative[`CONNECT_BIT];  // R10
			positiveDacLevel <=
				testDacPositive[`DAC_LEVEL_MSB:`DAC_LEVEL_LSB];  // R7
			negativeDacLevel <=
				testDacNegative[`DAC_LEVEL_MSB:`DAC_LEVEL_LSB];  // R9
		end
	end

	// Both DAC level fields are packed so one loop decodes them.
	assign dacCodes = {testDacNegative[`DAC_LEVEL_MSB:`DAC_LEVEL_LSB],
		testDacPositive[`DAC_LEVEL_MSB:`DAC_LEVEL_LSB]};

	// One decoder and one flag register per test DAC.
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : dacChannel
			dac_level_decode levelDecode (
				.code     (dacCodes[5*ch+4:5*ch]),
				.valid    (decValid[ch]),
				.aboveMid (decAbove[ch]),
				.belowMid (decBelow[ch]),
				.steps    ()
			);

			// Flags register alongside the level output.
			always @(posedge ref_clk) begin
				if (!rst_b) begin
					dacAbove[ch]    <= 1'b0;
					dacBelow[ch]    <= 1'b0;
					dacReserved[ch] <= 1'b0;
				end else begin
					dacAbove[ch]    <= decAbove[ch];  // R7
					dacBelow[ch]    <= decBelow[ch];  // R7
					dacReserved[ch] <= ~decValid[ch];  // R7
				end
			end
		end
	endgenerate

	// Flag outputs of the positive test DAC.
	assign positiveDacAboveMid     = dacAbove[0];
	assign positiveDacBelowMid     = dacBelow[0];
	assign positiveDacReservedCode = dacReserved[0];

	// Flag outputs of the negative test DAC.
	assign negativeDacAboveMid     = dacAbove[1];
	assign negativeDacBelowMid     = dacBelow[1];
	assign negativeDacReservedCode = dacReserved[1];

endmodule
`default_nettype wire

// ==== analog_config_map.vh ====
// Register indexes, field positions, reset values and codes for the slice.
`ifndef ANALOG_CONFIG_MAP_VH
`define ANALOG_CONFIG_MAP_VH

// Register indexes; the byte address is four times the index.
`define IDX_EXCITATION     6'h0E
`define IDX_REFERENCE      6'h0F
`define IDX_DAC_POSITIVE   6'h10
`define IDX_DAC_NEGATIVE   6'h11
`define IDX_ANALOG_STATUS  6'h20

// Reset values.
`define RESET_BYTE         8'h00
`define RESET_WORD         32'h00000000
`define RESET_CURRENT      12'h000
`define RESET_SELECT       5'h00

// Writable bit masks; cleared bits are reserved and read as zero.
`define MASK_EXCITATION    8'h0F
`define MASK_REFERENCE     8'h3F
`define MASK_DAC           8'h9F

// Field positions.
`define LEVEL_MSB          3
`define LEVEL_LSB          0
`define REFP_MSB           5
`define REFP_LSB           3
`define REFN_MSB           2
`define REFN_LSB           0
`define CONNECT_BIT        7
`define DAC_LEVEL_MSB      4
`define DAC_LEVEL_LSB      0
`define DAC_DOWN_BIT       4

// First-source level codes and currents in microamps.
`define LEVEL_OFF          4'h0
`define LEVEL_MAX          4'hA
`define CURRENT_UA_1       12'h032
`define CURRENT_UA_2       12'h064
`define CURRENT_UA_3       12'h0FA
`define CURRENT_UA_4       12'h1F4
`define CURRENT_UA_5       12'h2EE
`define CURRENT_UA_6       12'h3E8
`define CURRENT_UA_7       12'h5DC
`define CURRENT_UA_8       12'h7D0
`define CURRENT_UA_9       12'h9C4
`define CURRENT_UA_10      12'hBB8

// Reference selector codes and one-hot positions.
`define REFSEL_INTERNAL    3'h0
`define REFSEL_INPUT_A     3'h1
`define REFSEL_INPUT_B     3'h2
`define REFSEL_INPUT_C     3'h3
`define REFSEL_SUPPLY      3'h4
`define ONEHOT_INTERNAL    5'h01
`define ONEHOT_INPUT_A     5'h02
`define ONEHOT_INPUT_B     5'h04
`define ONEHOT_INPUT_C     5'h08
`define ONEHOT_SUPPLY      5'h10

// Test DAC level code limits.
`define DAC_MIDSCALE       5'h00
`define DAC_UP_MAX         4'h9
`define DAC_DOWN_MIN       4'h1
`define DAC_DOWN_MAX       4'h8

// Avalon-MM response codes.
`define RESP_OKAY          2'h0
`define RESP_DECODE_ERROR  2'h3

`endif

// ==== dac_level_decode.v ====
// Decoder that classifies one test DAC level code.
`timescale 1ns/100ps
`default_nettype none
`include "analog_config_map.vh"

module dac_level_decode (
	input  wire [4:0] code,
	output reg        valid,
	output reg        aboveMid,
	output reg        belowMid,
	output reg  [3:0] steps
);

	// Midscale, steps above with the top bit clear, steps below with it set.
	always @* begin
		steps    = code[3:0];
		valid    = 1'b0;
		aboveMid = 1'b0;
		belowMid = 1'b0;
		if (code == `DAC_MIDSCALE) begin
			valid = 1'b1;
		end else if (!code[`DAC_DOWN_BIT]) begin
			valid    = (code[3:0] <= `DAC_UP_MAX);
			aboveMid = valid;
		end else begin
			valid    = (code[3:0] >= `DAC_DOWN_MIN) &&
				(code[3:0] <= `DAC_DOWN_MAX);
			belowMid = valid;
		end
	end

endmodule
`default_nettype wire

// ==== analog_config_chk.sv ====
// Checker for bus timing and register effects of the analog slice.
`timescale 1ns/100ps
`default_nettype none
`include "analog_config_map.vh"
module analog_config_chk (
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic [7:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic [1:0]  response,
	input wire logic [3:0]  firstSourceLevel,
	input wire logic [11:0] firstSourceMicroamps,
	input wire logic        firstSourceOn,
	input wire logic [4:0]  refPositiveSelect,
	input wire logic        refPositiveReservedCode,
	input wire logic        positiveDacConnect,
	input wire logic        negativeDacConnect
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Accepted reads and writes and the word they address.
	wire [5:0] idx = address[7:2];
	wire       rdAcc = read && !waitrequest;
	wire       wrAcc = write && !waitrequest && byteenable[0];
	wire       mapped = idx inside {[6'h0E:6'h11], 6'h20};

	a_wait_once: assert property ($rose(read || write) |->
		waitrequest ##1 !waitrequest) else $error("wait state wrong");
	a_upper_zero: assert property (rdAcc |-> readdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	a_unmapped_err: assert property (rdAcc && !mapped |->
		response == `RESP_DECODE_ERROR && readdata == `RESET_WORD)
		else $error("unmapped read answered");
	a_ref_resv_zero: assert property (rdAcc && idx == `IDX_REFERENCE |->
		readdata[7:6] == 2'b00) else $error("ref reserved set");
	a_dac_resv_zero: assert property (rdAcc && idx[5:1] == 5'h08 |->
		readdata[6:5] == 2'b00) else $error("dac reserved set");
	a_level_follows: assert property (wrAcc && idx == `IDX_EXCITATION |->
		##2 firstSourceLevel == $past(writedata[3:0], 2))
		else $error("level not applied");
	a_current_on: assert property (firstSourceOn ==
		(firstSourceMicroamps != 12'h000)) else $error("on flag");
	a_refp_onehot: assert property ($onehot0(refPositiveSelect) &&
		refPositiveReservedCode == (refPositiveSelect == 5'h00))
		else $error("ref select code");
	a_pos_connect: assert property (wrAcc && idx == `IDX_DAC_POSITIVE |->
		##2 positiveDacConnect == $past(writedata[7], 2))
		else $error("pos connect");
	a_neg_connect: assert property (wrAcc && idx == `IDX_DAC_NEGATIVE |->
		##2 negativeDacConnect == $past(writedata[7], 2))
		else $error("neg connect");
endmodule
bind analog_config_register_slice analog_config_chk i_chk (.ref_clk,
	.rst_b, .address, .read, .write, .writedata, .byteenable, .readdata,
	.waitrequest, .response, .firstSourceLevel, .firstSourceMicroamps,
	.firstSourceOn, .refPositiveSelect, .refPositiveReservedCode,
	.positiveDacConnect, .negativeDacConnect);
`default_nettype wire

// ==== analog_config_register_slice_bench.sv ====
// Self-checking bench for the analog configuration register slice.
`timescale 1ns/100ps
`default_nettype none
`include "analog_config_map.vh"
module analog_config_register_slice_bench;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  address = 8'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h00000000;
	logic [3:0]  byteenable = 4'hF;
	logic [31:0] rd;
	logic [1:0]  rsp;
	int          err_count = 0;
	int          tests_run = 0;
	wire  [31:0] readdata;
	wire  [11:0] firstSourceMicroamps;
	wire  [4:0]  refPositiveSelect, refNegativeSelect;
	wire  [4:0]  positiveDacLevel, negativeDacLevel;
	wire  [3:0]  firstSourceLevel;
	wire  [1:0]  response;
	wire         waitrequest, firstSourceOn, firstSourceReservedCode;
	wire         refPositiveReservedCode, refNegativeReservedCode;
	wire         positiveDacConnect, negativeDacConnect;
	wire         positiveDacAboveMid, positiveDacBelowMid;
	wire         positiveDacReservedCode, negativeDacAboveMid;
	wire         negativeDacBelowMid, negativeDacReservedCode;
	logic [11:0] uaTable [0:15] = '{12'h000, 12'h032, 12'h064, 12'h0FA,
		12'h1F4, 12'h2EE, 12'h3E8, 12'h5DC, 12'h7D0, 12'h9C4, 12'hBB8,
		12'h000, 12'h000, 12'h000, 12'h000, 12'h000};
	logic [4:0]  dacCodes [0:7] = '{5'h00, 5'h01, 5'h09, 5'h0A, 5'h10,
		5'h11, 5'h18, 5'h1F};

	analog_config_register_slice i_dut (.ref_clk, .rst_b, .address, .read,
		.write, .writedata, .byteenable, .readdata, .waitrequest, .response,
		.firstSourceLevel, .firstSourceMicroamps, .firstSourceOn,
		.firstSourceReservedCode, .refPositiveSelect, .refNegativeSelect,
		.refPositiveReservedCode, .refNegativeReservedCode,
		.positiveDacConnect, .negativeDacConnect, .positiveDacLevel,
		.negativeDacLevel, .positiveDacAboveMid, .positiveDacBelowMid,
		.positiveDacReservedCode, .negativeDacAboveMid,
		.negativeDacBelowMid, .negativeDacReservedCode);

	// The clock runs at 200 MHz.
	always #2.5 ref_clk = ~ref_clk;

	// Compares one value and counts it.
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Compares one bus response code.
	task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: response %h expected %h", $time, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish;
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// One bus cycle; the request stands until waitrequest is seen low at a
	// rising edge, and read data and response are taken at that edge.
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [7:0] d, input logic [3:0] be);
		logic w;
		w = 1'b1;
		@(posedge ref_clk);
		address <= a;
		writedata <= {24'h000000, d};
		byteenable <= be;
		read <= !wr;
		write <= wr;
		for (int n = 0; n < 20 && w; n++) begin
			@(posedge ref_clk);
			w = waitrequest;
			if (w === 1'b0) begin
				rd = readdata;
				rsp = response;
			end
		end
		read <= 1'b0;
		write <= 1'b0;
		if (w !== 1'b0) begin
			err_count++;
			$display("ERROR %0t: bus timeout", $time);
			tally_and_finish;
		end
	endtask

	// Writes one byte and waits the one-edge lag of the outputs.
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1);
		@(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	// Reads one register and compares data and response.
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
		input logic [1:0] r);
		bus(1'b0, a, 8'h00, 4'hF);
		check_val(rd, {24'h000000, e});
		check_resp(rsp, r);
	endtask

	// Reset values of registers and outputs.
	task automatic test_reset;
		rd_chk(8'h38, `RESET_BYTE, `RESP_OKAY);
		rd_chk(8'h3C, `RESET_BYTE, `RESP_OKAY);
		rd_chk(8'h40, `RESET_BYTE, `RESP_OKAY);
		rd_chk(8'h44, `RESET_BYTE, `RESP_OKAY);
		check_val(refPositiveSelect, `ONEHOT_INTERNAL);
		check_val(refNegativeSelect, `ONEHOT_INTERNAL);
		check_val(firstSourceMicroamps, `RESET_CURRENT);
		check_val({positiveDacConnect, negativeDacConnect}, 2'b00);
		$display("test_reset done");
	endtask

	// Every first-source level code, reserved upper bits set.
	task automatic test_levels;
		for (int i = 0; i < 16; i++) begin
			wr_reg(8'h38, {4'hF, i[3:0]});
			check_val(firstSourceLevel, i[3:0]);
			check_val(firstSourceMicroamps, uaTable[i]);
			check_val(firstSourceOn, i inside {[1:10]});
			check_val(firstSourceReservedCode, i > 10);
			rd_chk(8'h38, {4'h0, i[3:0]}, `RESP_OKAY);
		end
		$display("test_levels done");
	endtask

	// Every reference selector code on both sides.
	task automatic test_refsel;
		logic [2:0] p;
		logic [2:0] n;
		for (int i = 0; i < 8; i++) begin
			p = i;
			n = 7 - i;
			wr_reg(8'h3C, {2'b11, p, n});
			check_val(refPositiveSelect, p < 5 ? 5'h01 << p : 5'h00);
			check_val(refNegativeSelect, n < 5 ? 5'h01 << n : 5'h00);
			check_val({refPositiveReservedCode, refNegativeReservedCode},
				{p > 4, n > 4});
			rd_chk(8'h3C, {2'b00, p, n}, `RESP_OKAY);
		end
		$display("test_refsel done");
	endtask

	// Boundary level codes and connect bits of both test DACs.
	task automatic test_dac;
		logic [4:0] c;
		logic [2:0] f;
		logic [7:0] a;
		for (int i = 0; i < 16; i++) begin
			c = dacCodes[i % 8];
			a = i < 8 ? 8'h40 : 8'h44;
			f = {c inside {[5'h01:5'h09]}, c inside {[5'h11:5'h18]}, 1'b0};
			f[0] = c != 5'h00 && f[2:1] == 2'b00;
			wr_reg(a, {i[0], 2'b11, c});
			if (i < 8) begin
				check_val({positiveDacConnect, positiveDacLevel}, {i[0], c});
				check_val({positiveDacAboveMid, positiveDacBelowMid,
					positiveDacReservedCode}, f);
			end else begin
				check_val({negativeDacConnect, negativeDacLevel}, {i[0], c});
				check_val({negativeDacAboveMid, negativeDacBelowMid,
					negativeDacReservedCode}, f);
			end
			rd_chk(a, {i[0], 2'b00, c}, `RESP_OKAY);
		end
		$display("test_dac done");
	endtask

	// Read-only status, masked write and unmapped accesses.
	task automatic test_refused;
		rd_chk(8'h80, 8'h36, `RESP_OKAY);
		bus(1'b1, 8'h80, 8'h00, 4'h1);
		rd_chk(8'h80, 8'h36, `RESP_OKAY);
		bus(1'b1, 8'h3C, 8'h24, 4'hE);
		rd_chk(8'h3C, 8'h38, `RESP_OKAY);
		bus(1'b1, 8'h04, 8'hFF, 4'h1);
		rd_chk(8'h04, 8'h00, `RESP_DECODE_ERROR);
		$display("test_refused done");
	endtask

	// Main sequence, with a second reset in mid-run.
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		test_reset();
		test_levels();
		test_refsel();
		test_dac();
		test_refused();
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		test_reset();
		tally_and_finish();
	end
endmodule
`default_nettype wire
